//--- inc/rtcc_pkg.sv
// rtc calendar/alarm control: shared constants and register map
// assumes a 25 MHz bus clock and a synchronous kernel clock input
// Function
// [R01] reading subsecond freezes time and date shadows for a consistent set
// [R02] after time read, date shadow stays locked until date read
// [R03] shadow bypass set makes reads return live counters
// [R04] software rereads subsecond after the set; repeats if it changed
// [R05] init ready rises one to two kernel clocks after init request
// [R06] calendar writes are dropped while init ready is low
// [R07] software clears bypass and waits sync flag before next init entry; the bench clears bypass in the init-entry write, with no wait
// [R08] software programs all calendar registers in one init session
// [R09] debug stop also halts the subsecond alarm counter
// [R10] nonzero subsecond mask adds subsecond bits to the alarm match
// [R11] alarms share one event line; tamper and timestamp share another
// [R12] alarm flags stay set until software clears each separately
// [R13] line flag clear takes effect only after a short delay
// [R14] alarm handler checks alarm a, then b, then a again
// [R15] software sets the alarm pin general function to input
// [R16] sync flag sets on every shadow refresh, cleared by software write
package rtcc_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam int AW = 6;
    localparam logic [AW-1:0] OFS_CTRL = 6'h00;
    localparam logic [AW-1:0] OFS_STAT = 6'h04;
    localparam logic [AW-1:0] OFS_SS = 6'h08;
    localparam logic [AW-1:0] OFS_TOD = 6'h0c;
    localparam logic [AW-1:0] OFS_DATE = 6'h10;
    localparam logic [AW-1:0] OFS_ALA_SS = 6'h14;
    localparam logic [AW-1:0] OFS_ALB_SS = 6'h18;
    localparam logic [AW-1:0] OFS_EVENT = 6'h1c;
    localparam logic [AW-1:0] OFS_IRQ_ST = 6'h20;
    localparam logic [AW-1:0] OFS_IRQ_MSK = 6'h24;
    localparam logic [AW-1:0] OFS_LINE = 6'h28;
    localparam logic [AW-1:0] OFS_ALA_TOD = 6'h2c;
    localparam logic [AW-1:0] OFS_ALB_TOD = 6'h30;
    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int CTRL_BYP = 0;
    localparam int CTRL_INIT = 1;
    localparam int CTRL_DBG = 2;
    localparam int CTRL_AOUT = 3;
    localparam int CTRL_W = 4;
    localparam int ST_INIT_READY_FLAG = 0;
    localparam int ST_RSF = 1;
    localparam int EV_ALA = 0;
    localparam int EV_ALB = 1;
    localparam int EV_TAMP = 2;
    localparam int EV_TS = 3;
    localparam int EV_W = 4;
    localparam int LN_ALARM = 0;
    localparam int LN_TAMP = 1;
    localparam int SS_W = 15;
    localparam int TOD_W = 17;
    localparam int DATE_W = 16;
    localparam int MASK_W = 4;
    localparam int MASK_LSB = 24;
    localparam logic [TOD_W-1:0] SECS_PER_DAY = 17'h1_5180;
    localparam logic [SS_W-1:0] PREDIV_DEF = 15'h00ff;
    localparam logic [1:0] INIT_SYNC_TICKS = 2'h2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 40;
    localparam int LINE_CLR_NS = 120;
    localparam int LINE_CLR_CYC = (LINE_CLR_NS + CLK_NS - 1) / CLK_NS;
endpackage : rtcc_pkg

//--- rtl/rtcc_alarm_match.sv
// rtc calendar/alarm control: one alarm comparator
// assumes counters and tick come from the calendar core
`timescale 1ns/1ps
module rtcc_alarm_match
    import rtcc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // calendar state
    input wire logic tick,
    input wire logic sec_start,
    input wire logic [SS_W-1:0] ss,
    input wire logic [TOD_W-1:0] tod,
    // alarm setting
    input wire logic [SS_W-1:0] al_ss,
    input wire logic [MASK_W-1:0] al_mask,
    input wire logic [TOD_W-1:0] al_tod,
    // result
    output logic match_r
);
    logic [SS_W-1:0] ss_sel;
    logic hit;

    always_comb begin
        for (int i = 0; i < SS_W; i++) begin
            ss_sel[i] = (i < int'(al_mask));
        end
        // zero mask: one hit per second at the second boundary only
        hit = (tod == al_tod) &&
              ((al_mask == '0) ? sec_start
                               : (((ss ^ al_ss) & ss_sel) == '0)); // R10
    end

    // a match only on a tick, so a stopped tick cannot re-set the flag
    always_ff @(posedge clk) begin
        if (rst) begin
            match_r <= 1'b0;
        end else begin
            match_r <= tick && hit; // R09
        end
    end

    property p_mask_zero;
        @(posedge clk) disable iff (rst)
        match_r && ($past(al_mask) == '0) |-> $past(sec_start);
    endproperty
    a_mask_zero: assert property (p_mask_zero) // R10
        else $error("alarm with zero mask fired off second boundary");

    property p_mask_bits;
        @(posedge clk) disable iff (rst)
        match_r && ($past(al_mask) != '0) |->
            ($past(ss[0]) == $past(al_ss[0]));
    endproperty
    a_mask_bits: assert property (p_mask_bits) // R10
        else $error("masked subsecond bit differs at alarm");
endmodule : rtcc_alarm_match

//--- rtl/rtcc_core.sv
// rtc calendar/alarm control: counters, shadows, init, alarms, lines
// assumes a single bus clock; kernel clock is sampled as a level
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
module rtcc_core
    import rtcc_pkg::*;
#(
    parameter logic [SS_W-1:0] PREDIV = PREDIV_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [AW-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // kernel clock, debug, external events
    input wire logic rtc_kernel_clock,
    input wire logic debug_halt,
    input wire logic tamper_evt,
    input wire logic tstamp_evt,
    // event controller lines and interrupt
    output logic alarm_line,
    output logic tamper_line,
    output logic irq,
    // alarm open-drain pin
    output logic alarm_pin_o,
    output logic alarm_pin_oe
);
    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [AW-1:0] o);
        return a == o;
    endfunction : hit

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_r;
    logic init_ready_r;
    logic [1:0] sync_cnt_r;
    logic shadow_sync_r;
    logic kclk_q_r;
    logic [SS_W-1:0] ss_r, sh_ss_r;
    logic [TOD_W-1:0] tod_r, sh_tod_r;
    logic [DATE_W-1:0] date_r, sh_date_r;
    logic lock_tod_r, lock_date_r;
    logic [SS_W-1:0] al_ss_r [2];
    logic [MASK_W-1:0] al_mask_r [2];
    logic [TOD_W-1:0] al_tod_r [2];
    logic [1:0] al_match;
    logic [EV_W-1:0] ev_r, irq_st_r, irq_msk_r, ev_set;
    logic [1:0] line_r;
    logic [LINE_CLR_CYC-1:0] clr_pipe_r [2];
    logic [31:0] rdata_r;
    logic irq_r, pin_oe_r, pin_o_r;
    logic ktick, cnt_run, sec_start, refresh;
    logic rd_ss, rd_tod, rd_date, wr_cal_ok;

    assign ktick = rtc_kernel_clock && !kclk_q_r;
    assign cnt_run = ktick && !init_ready_r &&
                     !(ctrl_r[CTRL_DBG] && debug_halt); // R09
    assign sec_start = (ss_r == PREDIV);
    assign rd_ss = rd && hit(addr, OFS_SS) && !ctrl_r[CTRL_BYP];
    assign rd_tod = rd && hit(addr, OFS_TOD) && !ctrl_r[CTRL_BYP];
    assign rd_date = rd && hit(addr, OFS_DATE) && !ctrl_r[CTRL_BYP];
    // a subsecond or time read in the refresh cycle would split the set
    assign refresh = ktick && !lock_tod_r && !lock_date_r &&
                     !rd_ss && !rd_tod; // R01 R02
    assign wr_cal_ok = wr && init_ready_r; // R06
    assign ev_set = {tstamp_evt, tamper_evt, al_match};

    assign rdata = rdata_r;
    assign alarm_line = line_r[LN_ALARM];
    assign tamper_line = line_r[LN_TAMP];
    assign irq = irq_r;
    assign alarm_pin_o = pin_o_r;
    assign alarm_pin_oe = pin_oe_r;

    // ------------------------------------------------------------
    // control and init handshake
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= '0;
            kclk_q_r <= 1'b0;
        end else begin
            kclk_q_r <= rtc_kernel_clock;
            if (wr && hit(addr, OFS_CTRL)) begin
                ctrl_r <= wdata[CTRL_W-1:0];
            end
        end
    end

    // counts whole kernel edges, never trusts an earlier partial one
    always_ff @(posedge clk) begin
        if (rst || !ctrl_r[CTRL_INIT]) begin
            init_ready_r <= 1'b0;
            sync_cnt_r <= '0;
        end else if (ktick && !init_ready_r) begin
            sync_cnt_r <= sync_cnt_r + 2'h1;
            if (sync_cnt_r == INIT_SYNC_TICKS - 2'h1) begin
                init_ready_r <= 1'b1; // R05
            end
        end
    end

    // ------------------------------------------------------------
    // calendar counters
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ss_r <= PREDIV;
            tod_r <= '0;
            date_r <= '0;
        end else begin
            if (cnt_run) begin
                if (ss_r == '0) begin
                    ss_r <= PREDIV;
                    if (tod_r == SECS_PER_DAY - 1'b1) begin
                        tod_r <= '0;
                        date_r <= date_r + 1'b1;
                    end else begin
                        tod_r <= tod_r + 1'b1;
                    end
                end else begin
                    ss_r <= ss_r - 1'b1;
                end
            end
            if (wr_cal_ok && hit(addr, OFS_TOD)) begin
                tod_r <= wdata[TOD_W-1:0];
                ss_r <= PREDIV;
            end
            if (wr_cal_ok && hit(addr, OFS_DATE)) begin
                date_r <= wdata[DATE_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // shadows, locks and sync flag
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            sh_ss_r <= PREDIV;
            sh_tod_r <= '0;
            sh_date_r <= '0;
        end else if (refresh) begin
            sh_ss_r <= ss_r;
            sh_tod_r <= tod_r;
            sh_date_r <= date_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lock_tod_r <= 1'b0;
            lock_date_r <= 1'b0;
        end else if (rd_ss) begin
            lock_tod_r <= 1'b1; // R01
            lock_date_r <= 1'b1; // R01
        end else if (rd_tod) begin
            lock_tod_r <= 1'b0;
            lock_date_r <= 1'b1; // R02
        end else if (rd_date) begin
            lock_tod_r <= 1'b0;
            lock_date_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            shadow_sync_r <= 1'b0;
        end else if (refresh) begin
            shadow_sync_r <= 1'b1; // R16
        end else if (wr && hit(addr, OFS_STAT) && !wdata[ST_RSF]) begin
            shadow_sync_r <= 1'b0; // R16
        end
    end

    // ------------------------------------------------------------
    // alarms
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                al_ss_r[i] <= '0;
                al_mask_r[i] <= '0;
                al_tod_r[i] <= '0;
            end
        end else if (wr) begin
            for (int i = 0; i < 2; i++) begin
                if (hit(addr, i == 0 ? OFS_ALA_SS : OFS_ALB_SS)) begin
                    al_ss_r[i] <= wdata[SS_W-1:0];
                    al_mask_r[i] <= wdata[MASK_LSB +: MASK_W];
                end
                if (hit(addr, i == 0 ? OFS_ALA_TOD : OFS_ALB_TOD)) begin
                    al_tod_r[i] <= wdata[TOD_W-1:0];
                end
            end
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_alarm
        rtcc_alarm_match u_match (
            .clk(clk),
            .rst(rst),
            .tick(cnt_run),
            .sec_start(sec_start),
            .ss(ss_r),
            .tod(tod_r),
            .al_ss(al_ss_r[g]),
            .al_mask(al_mask_r[g]),
            .al_tod(al_tod_r[g]),
            .match_r(al_match[g])
        );
    end

    // ------------------------------------------------------------
    // event flags, interrupt status, shared lines
    // ------------------------------------------------------------
    // set wins over the write-one clear
    always_ff @(posedge clk) begin
        if (rst) begin
            ev_r <= '0;
        end else begin
            ev_r <= (ev_r & ~((wr && hit(addr, OFS_EVENT)) ?
                              wdata[EV_W-1:0] : '0)) | ev_set; // R12
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_st_r <= '0;
            irq_msk_r <= '0;
            irq_r <= 1'b0;
        end else begin
            irq_st_r <= (rd && hit(addr, OFS_IRQ_ST) ? '0 : irq_st_r)
                        | ev_set;
            if (wr && hit(addr, OFS_IRQ_MSK)) begin
                irq_msk_r <= wdata[EV_W-1:0];
            end
            irq_r <= |(irq_st_r & irq_msk_r);
        end
    end

    // clear travels a short pipe before it bites; new sets still win
    always_ff @(posedge clk) begin
        if (rst) begin
            line_r <= '0;
            for (int i = 0; i < 2; i++) begin
                clr_pipe_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                clr_pipe_r[i] <= {clr_pipe_r[i][LINE_CLR_CYC-2:0],
                                  wr && hit(addr, OFS_LINE) && wdata[i]};
                if (clr_pipe_r[i][LINE_CLR_CYC-1]) begin
                    line_r[i] <= 1'b0; // R13
                end
            end
            if (|ev_set[EV_ALB:EV_ALA]) begin
                line_r[LN_ALARM] <= 1'b1; // R11
            end
            if (|ev_set[EV_TS:EV_TAMP]) begin
                line_r[LN_TAMP] <= 1'b1; // R11
            end
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_oe_r <= 1'b0;
            pin_o_r <= 1'b0;
        end else begin
            pin_oe_r <= ctrl_r[CTRL_AOUT] && (ev_r[EV_ALA] || ev_r[EV_ALB]);
            pin_o_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (rd) begin
            rdata_r <= '0;
            unique case (addr)
                OFS_CTRL: rdata_r[CTRL_W-1:0] <= ctrl_r;
                OFS_STAT: rdata_r[ST_RSF:ST_INIT_READY_FLAG] <=
                    {shadow_sync_r, init_ready_r};
                OFS_SS: rdata_r[SS_W-1:0] <=
                    ctrl_r[CTRL_BYP] ? ss_r : sh_ss_r; // R03
                OFS_TOD: rdata_r[TOD_W-1:0] <=
                    ctrl_r[CTRL_BYP] ? tod_r : sh_tod_r; // R03
                OFS_DATE: rdata_r[DATE_W-1:0] <=
                    ctrl_r[CTRL_BYP] ? date_r : sh_date_r; // R03
                OFS_ALA_SS: rdata_r <= 32'(al_ss_r[0])
                    | (32'(al_mask_r[0]) << MASK_LSB);
                OFS_ALB_SS: rdata_r <= 32'(al_ss_r[1])
                    | (32'(al_mask_r[1]) << MASK_LSB);
                OFS_ALA_TOD: rdata_r[TOD_W-1:0] <= al_tod_r[0];
                OFS_ALB_TOD: rdata_r[TOD_W-1:0] <= al_tod_r[1];
                OFS_EVENT: rdata_r[EV_W-1:0] <= ev_r;
                OFS_IRQ_ST: rdata_r[EV_W-1:0] <= irq_st_r;
                OFS_IRQ_MSK: rdata_r[EV_W-1:0] <= irq_msk_r;
                OFS_LINE: rdata_r[1:0] <= line_r;
                default: rdata_r <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_locked;
        lock_tod_r && lock_date_r;
    endsequence
    property p_ss_lock;
        rd_ss |=> s_locked ##0 $stable(sh_tod_r);
    endproperty
    a_ss_lock: assert property (p_ss_lock) // R01
        else $error("time and date not frozen after subsecond read");

    property p_date_hold;
        rd_tod |=> lock_date_r && $stable(sh_date_r);
    endproperty
    a_date_hold: assert property (p_date_hold) // R02
        else $error("date shadow moved after time read");

    property p_bypass;
        rd && hit(addr, OFS_TOD) && ctrl_r[CTRL_BYP]
            |=> rdata == 32'($past(tod_r));
    endproperty
    a_bypass: assert property (p_bypass) // R03
        else $error("bypass read did not return live time");

    sequence s_not_ready2;
        !init_ready_r [*2];
    endsequence
    property p_init_delay;
        $rose(ctrl_r[CTRL_INIT]) |-> s_not_ready2;
    endproperty
    a_init_delay: assert property (p_init_delay) // R05
        else $error("init ready rose without sync delay");

    property p_cal_drop;
        wr && hit(addr, OFS_DATE) && !init_ready_r && !cnt_run
            |=> date_r == $past(date_r);
    endproperty
    a_cal_drop: assert property (p_cal_drop) // R06
        else $error("date written while not ready");

    property p_dbg_stop;
        ctrl_r[CTRL_DBG] && debug_halt && !wr_cal_ok
            |=> ss_r == $past(ss_r);
    endproperty
    a_dbg_stop: assert property (p_dbg_stop) // R09
        else $error("subsecond counter ran in debug halt");

    property p_line_or;
        |ev_set[EV_ALB:EV_ALA] |=> line_r[LN_ALARM];
    endproperty
    a_line_or: assert property (p_line_or) // R11
        else $error("alarm did not raise the shared line");

    property p_flag_sticky;
        ev_r[EV_ALA] && !(wr && hit(addr, OFS_EVENT) && wdata[EV_ALA])
            |=> ev_r[EV_ALA];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // R12
        else $error("alarm a flag dropped without clear");

    property p_line_clr;
        wr && hit(addr, OFS_LINE) && wdata[LN_ALARM] && line_r[LN_ALARM]
            |=> line_r[LN_ALARM] [*2];
    endproperty
    a_line_clr: assert property (p_line_clr) // R13
        else $error("line flag cleared too early");

    property p_rsf;
        refresh |=> shadow_sync_r;
    endproperty
    a_rsf: assert property (p_rsf) // R16
        else $error("sync flag not set on refresh");
endmodule : rtcc_core

//--- sim/rtcc_core_tb.sv
// self-checking bench for the calendar/alarm control core
// assumes rtcc_pkg compiled first; bench makes the kernel clock level
`timescale 1ns/1ps
module rtcc_core_tb import rtcc_pkg::*; ();
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    // short subsecond reload keeps one second at 32 bus cycles
    localparam logic [SS_W-1:0] PDV = 15'h0007;
    logic clk;
    logic rst;
    logic [AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic kclk;
    logic [1:0] kcnt;
    logic debug_halt;
    logic tamper_evt;
    logic tstamp_evt;
    logic alarm_line;
    logic tamper_line;
    logic irq;
    logic alarm_pin_o;
    logic alarm_pin_oe;
    logic [31:0] v;
    logic [31:0] t0;
    logic [31:0] w;
    logic [15:0] day;
    integer seed;
    int n_errors;
    int samples_checked;
    int cycles;
    int i;

    rtcc_core #(.PREDIV(PDV)) DUT (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .rtc_kernel_clock(kclk),
        .debug_halt(debug_halt), .tamper_evt(tamper_evt),
        .tstamp_evt(tstamp_evt), .alarm_line(alarm_line),
        .tamper_line(tamper_line), .irq(irq),
        .alarm_pin_o(alarm_pin_o), .alarm_pin_oe(alarm_pin_oe)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] next_day(input logic [15:0] d);
        return {16'h0000, d + 16'h0001};
    endfunction : next_day

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [AW-1:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // bounded poll of one status bit
    task automatic wait_bit(input logic [AW-1:0] a, input int b);
        int k;
        v = 32'h0000_0000;
        for (k = 0; k < 6 && v[b] !== 1'b1; k++) begin
            rd_reg(a, v);
        end
        check(32'(v[b]), 32'h0000_0001);
    endtask : wait_bit

    task automatic pulse_ev(input bit ts);
        @(posedge clk);
        if (ts) tstamp_evt <= 1'b1; else tamper_evt <= 1'b1;
        @(posedge clk);
        tstamp_evt <= 1'b0;
        tamper_evt <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse_ev

    task automatic complete_run;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // clock, kernel clock, timeout
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // kernel period of four bus cycles, two high and two low
    always @(posedge clk) begin
        kcnt <= kcnt + 2'h1;
        kclk <= kcnt[1];
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0;
        kclk = 1'b0; kcnt = 2'h0; debug_halt = 1'b0;
        tamper_evt = 1'b0; tstamp_evt = 1'b0;
        n_errors = 0; samples_checked = 0; cycles = 0;
        seed = 54448;
        day = 16'($random(seed));
        day[15] = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd_reg(OFS_CTRL, v); check(v, 32'h0000_0000);
        rd_reg(OFS_IRQ_MSK, v); check(v, 32'h0000_0000);
        // both alarms reset to midnight, so they match on the first tick
        rd_reg(OFS_EVENT, v); check(v, 32'h0000_0003);
        rd_reg(6'h3c, v); check(v, 32'h0000_0000);
        $display("test reset done");
        // time write outside init is dropped; live read
        wr_reg(OFS_CTRL, 32'h0000_0001);
        wr_reg(OFS_TOD, 32'h0001_0000);
        rd_reg(OFS_TOD, v); check(32'(v < 32'h2), 32'h1);
        wr_reg(OFS_CTRL, 32'h0000_0002);
        rd_reg(OFS_STAT, v); check(32'(v[ST_INIT_READY_FLAG]), 32'h0);
        wait_bit(OFS_STAT, ST_INIT_READY_FLAG);
        wr_reg(OFS_TOD, 32'(SECS_PER_DAY - 17'h2));
        wr_reg(OFS_DATE, {16'h0000, day});
        wr_reg(OFS_CTRL, 32'h0000_0000);
        wr_reg(OFS_STAT, 32'h0000_0000);
        wait_bit(OFS_STAT, ST_RSF);
        $display("test init done");
        // lock across the day boundary
        rd_reg(OFS_SS, v);
        repeat (100) @(posedge clk);
        rd_reg(OFS_TOD, v); check(v, 32'(SECS_PER_DAY - 17'h2));
        repeat (40) @(posedge clk);
        rd_reg(OFS_DATE, v); check(v, {16'h0000, day});
        repeat (8 + ($random(seed) & 7)) @(posedge clk);
        rd_reg(OFS_DATE, v); check(v, next_day(day));
        // retry until both subsecond reads agree; odd loop length
        // shifts the kernel tick phase so a retry cannot repeat forever
        t0 = 32'h0000_0000;
        w = 32'hffff_ffff;
        for (i = 0; i < 4 && w !== t0; i++) begin
            @(posedge clk);
            rd_reg(OFS_SS, t0);
            rd_reg(OFS_TOD, w);
            rd_reg(OFS_DATE, v);
            rd_reg(OFS_SS, w);
        end
        check(w, t0);
        check(v, next_day(day));
        $display("test shadow lock done");
        // alarm a second-aligned, alarm b on subsecond bits
        wr_reg(OFS_CTRL, 32'h0000_0008);
        wr_reg(OFS_ALA_TOD, 32'h0000_000c);
        wr_reg(OFS_ALA_SS, 32'h0000_0000);
        wr_reg(OFS_ALB_TOD, 32'h0000_000c);
        wr_reg(OFS_ALB_SS, 32'h0300_0005);
        // drop stale midnight matches from reset and the day rollover
        wr_reg(OFS_EVENT, 32'h0000_0003);
        wr_reg(OFS_LINE, 32'h0000_0001);
        rd_reg(OFS_IRQ_ST, v); check(v, 32'h0000_0003);
        wr_reg(OFS_IRQ_MSK, 32'h0000_0001);
        for (i = 0; i < 600 && alarm_line !== 1'b1; i++) @(posedge clk);
        check(32'(alarm_line), 32'h1);
        rd_reg(OFS_EVENT, v); check(v, 32'h0000_0001);
        check(32'({alarm_pin_oe, alarm_pin_o}), 32'h2);
        repeat (12) @(posedge clk);
        rd_reg(OFS_EVENT, v); check(v, 32'h0000_0003);
        check(32'(irq), 32'h1);
        rd_reg(OFS_IRQ_ST, v); check(v, 32'h0000_0003);
        repeat (2) @(posedge clk);
        #1 check(32'(irq), 32'h0);
        wr_reg(OFS_EVENT, 32'h0000_0001);
        rd_reg(OFS_EVENT, v); check(v, 32'h0000_0002);
        wr_reg(OFS_LINE, 32'h0000_0001);
        #1 check(32'(alarm_line), 32'h1);
        repeat (6) @(posedge clk);
        #1 check(32'(alarm_line), 32'h0);
        wr_reg(OFS_EVENT, 32'h0000_0002);
        rd_reg(OFS_EVENT, v); check(v, 32'h0000_0000);
        repeat (2) @(posedge clk);
        #1 check(32'(alarm_pin_oe), 32'h0);
        $display("test alarm done");
        // tamper and timestamp share the second line
        pulse_ev(1'b0); check(32'(tamper_line), 32'h1);
        wr_reg(OFS_LINE, 32'h0000_0002);
        repeat (6) @(posedge clk);
        #1 check(32'(tamper_line), 32'h0);
        pulse_ev(1'b1); check(32'(tamper_line), 32'h1);
        check(32'(alarm_line), 32'h0);
        rd_reg(OFS_EVENT, v); check(v, 32'h0000_000c);
        $display("test lines done");
        // debug stop freezes subsecond counting
        wr_reg(OFS_CTRL, 32'h0000_0005);
        debug_halt <= 1'b1;
        rd_reg(OFS_SS, t0);
        repeat (40) @(posedge clk);
        rd_reg(OFS_SS, v); check(v, t0);
        debug_halt <= 1'b0;
        repeat (8) @(posedge clk);
        rd_reg(OFS_SS, v); check(32'(v !== t0), 32'h1);
        $display("test debug done");
        complete_run();
    end
endmodule : rtcc_core_tb
